// ### verilog/sscf_frame_ctrl.sv
// Session control frame decoder with incoming session table
//
// Behaviour
// (RL1) Frame opens with one start marker byte
// (RL2) Length counts bytes between length and checksum
// (RL3) Sender puts type 0x2E at position three
// (RL4) Sender supplies 64-bit target address from four
// (RL5) Broadcast address applies to all incoming sessions
// (RL6) Options bit0 clear starts client login
// (RL7) Bit0 set ends client session, ignores rest
// (RL8) Bit1 set ends incoming sessions, one or all
// (RL9) Bit2 selects the session timeout type
// (RL10) Timeout field at thirteen, at most 0x4650
// (RL11) Zero timeout makes a yielding session
// (RL12) Full server evicts oldest yielding session only
// (RL13) Password from fifteen, ignored unless login
// (RL14) Checksum is 0xFF minus body sum
// (RL15) Broadcast login fails with invalid-value status
// (RL16) Login outcome goes out as 0xAE response
// (RL17) Options 0x04 inter-packet, zero fixed login
// (RL18) Bad checksum or length frame is discarded
`timescale 1ns/1ps

module sscf_frame_ctrl #(
	parameter int MAX_SESS = 4,
	parameter int PW_MAX   = 64
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       rx_valid,
	input  wire logic [7:0]                 rx_byte,
	output sscf_pkg::sscf_login_t           login_cmd,
	output logic                            login_req,
	input  wire logic [$clog2(PW_MAX)-1:0]  pw_rd_addr,
	output logic      [7:0]                 pw_rd_data,
	output logic                            logout_req,
	output logic      [63:0]                logout_addr,
	input  wire logic                       srp_done,
	input  wire logic                       srp_ok,
	output logic                            resp_valid,
	output sscf_pkg::sscf_resp_t            resp,
	input  wire logic                       in_req,
	input  wire logic [63:0]                in_addr,
	input  wire logic                       in_yield,
	output logic                            in_ack,
	output logic                            in_nak,
	output logic                            evict_valid,
	output logic      [63:0]                evict_addr,
	output logic                            term_valid,
	output logic      [7:0]                 sess_count,
	output logic                            frame_err
);

	// ==========================================================
	// Parameter check
	localparam int PW_AW = $clog2(PW_MAX);                   // Password address width
	if (MAX_SESS < 1 || MAX_SESS > 255 || PW_MAX < 2 || PW_MAX > 64) begin : g_bad_param
		$error("sscf_frame_ctrl: session count or password size out of range");
	end

	// ==========================================================
	// State record
	typedef struct packed {
		sscf_pkg::sscf_state_t                 state;        // Receive state
		logic [15:0]                           len;          // Body length field
		logic [15:0]                           idx;          // Body byte index
		logic [7:0]                            sum;          // Running body sum
		logic                                  bad_len;      // Length out of range
		logic                                  foreign;      // Not a session frame
		sscf_pkg::sscf_cmd_t                   cmd;          // Collected fields
		sscf_pkg::sscf_login_t                 login;        // Login order
		logic                                  login_req;    // Login pulse
		logic                                  pending;      // Login awaiting outcome
		logic                                  logout_req;   // Logout pulse
		logic [63:0]                           logout_addr;  // Logout target
		logic                                  resp_valid;   // Response pulse
		sscf_pkg::sscf_resp_t                  resp;         // Response content
		logic                                  frame_err;    // Discard pulse
		logic                                  in_ack;       // Admission pulse
		logic                                  in_nak;       // Refusal pulse
		logic                                  evict_valid;  // Eviction pulse
		logic [63:0]                           evict_addr;   // Evicted client
		logic                                  term_valid;   // Termination pulse
		logic [7:0]                            sess_count;   // Sessions in use
		logic                                  pw_we;        // Password write strobe
		logic [PW_AW-1:0]                      pw_wa;        // Password write address
		logic [7:0]                            pw_wd;        // Password write data
		sscf_pkg::sscf_slot_t [MAX_SESS-1:0]   slots;        // Incoming sessions
	} sscf_ctrl_state_t;

	sscf_ctrl_state_t state_reg; // Current state
	sscf_ctrl_state_t state_next; // Next state

	// ==========================================================
	// Helpers
	// Add a byte into the running sum, modulo 256
	function automatic logic [7:0] sscf_sum_add(input logic [7:0] a, input logic [7:0] b);
		sscf_sum_add = a + b;
	endfunction

	// Broadcast target test
	function automatic logic sscf_is_bcast(input logic [63:0] a);
		sscf_is_bcast = (a == sscf_pkg::BCAST_ADDR);
	endfunction

	// Count of occupied slots
	function automatic logic [7:0] sscf_count(input sscf_pkg::sscf_slot_t [MAX_SESS-1:0] s);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < MAX_SESS; i++) begin
			c = c + {7'h00, s[i].valid};
		end
		sscf_count = c;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		int free_i;
		int old_i;
		int tgt_i;
		logic [7:0] old_age;
		logic [15:0] body_idx;
		sscf_pkg::sscf_slot_t [MAX_SESS-1:0] sl;
		free_i = -1;
		old_i = -1;
		tgt_i = 0;
		old_age = 8'h00;
		body_idx = state_reg.idx - sscf_pkg::IDX_PW;
		state_next = state_reg;
		// Pulses last one cycle
		state_next.login_req = 1'b0;
		state_next.logout_req = 1'b0;
		state_next.resp_valid = 1'b0;
		state_next.frame_err = 1'b0;
		state_next.in_ack = 1'b0;
		state_next.in_nak = 1'b0;
		state_next.evict_valid = 1'b0;
		state_next.term_valid = 1'b0;
		state_next.pw_we = 1'b0;

		case (state_reg.state)
			// Wait for a start marker; other bytes between frames are dropped
			sscf_pkg::ST_IDLE: begin
				if (rx_valid && rx_byte == sscf_pkg::START_MARK) begin   // [RL1]
					state_next.state = sscf_pkg::ST_LEN_HI;
				end
			end
			// Length, high byte first
			sscf_pkg::ST_LEN_HI: begin
				if (rx_valid) begin
					state_next.len = {rx_byte, 8'h00};
					state_next.state = sscf_pkg::ST_LEN_LO;
				end
			end
			// Low byte completes the length and its range check
			sscf_pkg::ST_LEN_LO: begin
				if (rx_valid) begin
					state_next.len = {state_reg.len[15:8], rx_byte};      // [RL2]
					state_next.idx = sscf_pkg::RST_WORD;
					state_next.sum = sscf_pkg::RST_BYTE;
					state_next.foreign = 1'b0;
					state_next.bad_len = ({state_reg.len[15:8], rx_byte} < sscf_pkg::HDR_LEN) ||
						({state_reg.len[15:8], rx_byte} >
						(sscf_pkg::HDR_LEN + sscf_pkg::PW_MAX_LEN));       // [RL2] [RL13]
					if ({state_reg.len[15:8], rx_byte} == sscf_pkg::RST_WORD) begin
						// Empty body: nothing to checksum, drop it
						state_next.frame_err = 1'b1; // [RL18]
						state_next.state = sscf_pkg::ST_IDLE;
					end else begin
						state_next.state = sscf_pkg::ST_BODY;
					end
				end
			end
			// Body bytes: collect fields, store password, sum everything
			sscf_pkg::ST_BODY: begin
				if (rx_valid) begin
					state_next.sum = sscf_sum_add(state_reg.sum, rx_byte); // [RL14]
					state_next.idx = state_reg.idx + 16'h0001;
					if (state_reg.idx == sscf_pkg::IDX_TYPE) begin
						// Other frame types are not ours
						state_next.foreign = (rx_byte != sscf_pkg::FRAME_TYPE);  // [RL3]
					end else if (state_reg.idx <= sscf_pkg::IDX_ADDR_HI) begin
						// Address arrives most significant byte first
						state_next.cmd.addr = {state_reg.cmd.addr[55:0], rx_byte}; // [RL4]
					end else if (state_reg.idx == sscf_pkg::IDX_OPT) begin
						state_next.cmd.opt = rx_byte;
					end else if (state_reg.idx == sscf_pkg::IDX_TMO_HI) begin
						state_next.cmd.tmo = {rx_byte, 8'h00};           // [RL10]
					end else if (state_reg.idx == sscf_pkg::IDX_TMO_LO) begin
						state_next.cmd.tmo = {state_reg.cmd.tmo[15:8], rx_byte}; // [RL10]
					end else if (body_idx < 16'(PW_MAX)) begin
						// Password bytes in arrival order
						state_next.pw_we = 1'b1; // [RL13]
						state_next.pw_wa = body_idx[PW_AW-1:0];
						state_next.pw_wd = rx_byte;
					end
					if (state_reg.idx == state_reg.len - 16'h0001) begin
						state_next.state = sscf_pkg::ST_CSUM;
					end
				end
			end
			// Checksum byte decides whether the frame counts
			sscf_pkg::ST_CSUM: begin
				if (rx_valid) begin
					if (sscf_sum_add(state_reg.sum, rx_byte) != sscf_pkg::CSUM_TARGET ||
						state_reg.bad_len) begin
						state_next.frame_err = 1'b1; // [RL14] [RL18]
						state_next.state = sscf_pkg::ST_IDLE;
					end else if (state_reg.foreign) begin
						state_next.state = sscf_pkg::ST_IDLE;
					end else begin
						state_next.state = sscf_pkg::ST_EXEC;
					end
				end
			end
			// Act on a good frame
			sscf_pkg::ST_EXEC: begin
				state_next.state = sscf_pkg::ST_IDLE;
				if (state_reg.cmd.opt[sscf_pkg::OPT_LOGOUT]) begin
					// Client logout; other options, timeout and password unused
					state_next.logout_req = 1'b1; // [RL7] [RL13]
					state_next.logout_addr = state_reg.cmd.addr;
				end else if (state_reg.cmd.opt[sscf_pkg::OPT_SERVER]) begin
					// Server side: end one client's sessions or all of them
					for (int i = 0; i < MAX_SESS; i++) begin
						if (sscf_is_bcast(state_reg.cmd.addr) ||
							state_reg.slots[i].addr == state_reg.cmd.addr) begin // [RL5] [RL8]
							state_next.slots[i].valid = 1'b0;
						end
					end
					state_next.term_valid = 1'b1; // [RL8]
				end else if (sscf_is_bcast(state_reg.cmd.addr) ||
					state_reg.cmd.tmo > sscf_pkg::TMO_MAX) begin
					// Sessions are end to end; oversize timeout is refused too
					state_next.resp_valid = 1'b1;                        // [RL15] [RL10]
					state_next.resp.ftype = sscf_pkg::RESP_TYPE;         // [RL16]
					state_next.resp.status = sscf_pkg::STAT_INVALID;     // [RL15]
				end else begin
					// Client login handed to the authentication engine
					state_next.login_req = 1'b1; // [RL6]
					state_next.pending = 1'b1;
					state_next.login.addr = state_reg.cmd.addr;
					state_next.login.tmo = state_reg.cmd.tmo;
					state_next.login.inter = state_reg.cmd.opt[sscf_pkg::OPT_TTYPE]; // [RL9] [RL17]
					state_next.login.yield_s = (state_reg.cmd.tmo == sscf_pkg::TMO_YIELD); // [RL11]
					state_next.login.pw_len = 7'(state_reg.len - sscf_pkg::HDR_LEN);
				end
			end
			default: begin
				state_next.state = sscf_pkg::ST_IDLE;
			end
		endcase

		// Outcome of an outstanding login becomes a response frame
		if (srp_done && state_reg.pending) begin
			state_next.pending = 1'b0;
			state_next.resp_valid = 1'b1; // [RL16]
			state_next.resp.ftype = sscf_pkg::RESP_TYPE;
			state_next.resp.status = srp_ok ? sscf_pkg::STAT_OK : sscf_pkg::STAT_FAIL;
		end

		// Incoming session requests, seen after any termination above
		sl = state_next.slots;
		if (in_req) begin
			for (int i = 0; i < MAX_SESS; i++) begin
				if (!sl[i].valid && free_i < 0) begin
					free_i = i;
				end
				if (sl[i].valid && sl[i].yield_s && (old_i < 0 || sl[i].age >= old_age)) begin
					old_i = i;
					old_age = sl[i].age;
				end
			end
			if (free_i >= 0 || old_i >= 0) begin
				if (free_i >= 0) begin
					tgt_i = free_i;
				end else begin
					// Table full: only a yielding session may give way
					tgt_i = old_i;                                       // [RL12]
					state_next.evict_valid = 1'b1;                       // [RL12]
					state_next.evict_addr = sl[old_i].addr;
				end
				// Older sessions grow older, saturating
				for (int i = 0; i < MAX_SESS; i++) begin
					if (sl[i].valid && sl[i].age != 8'hFF) begin
						sl[i].age = sl[i].age + 8'h01;
					end
				end
				sl[tgt_i].valid = 1'b1;
				sl[tgt_i].yield_s = in_yield;
				sl[tgt_i].age = sscf_pkg::RST_BYTE;
				sl[tgt_i].addr = in_addr;
				state_next.in_ack = 1'b1;
			end else begin
				// Full of timed sessions: these are never ended to make room
				state_next.in_nak = 1'b1;                                // [RL12]
			end
		end
		state_next.slots = sl;
		state_next.sess_count = sscf_count(sl);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Password buffer
	sscf_pw_mem #(
		.WIDTH (8),
		.DEPTH (PW_MAX)
	) u_pw_mem (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (state_reg.pw_we),
		.wr_addr (state_reg.pw_wa),
		.wr_data (state_reg.pw_wd),
		.rd_addr (pw_rd_addr),
		.rd_data (pw_rd_data)
	);

	// Outputs straight from the state register
	assign login_cmd   = state_reg.login;
	assign login_req   = state_reg.login_req;
	assign logout_req  = state_reg.logout_req;
	assign logout_addr = state_reg.logout_addr;
	assign resp_valid  = state_reg.resp_valid;
	assign resp        = state_reg.resp;
	assign in_ack      = state_reg.in_ack;
	assign in_nak      = state_reg.in_nak;
	assign evict_valid = state_reg.evict_valid;
	assign evict_addr  = state_reg.evict_addr;
	assign term_valid  = state_reg.term_valid;
	assign sess_count  = state_reg.sess_count;
	assign frame_err   = state_reg.frame_err;

endmodule // sscf_frame_ctrl

// ### verilog/sscf_pkg.sv
// Shared constants and carrier types of the session control frame decoder
package sscf_pkg;

	// ==========================================================
	// Frame framing constants
	localparam logic [7:0]  START_MARK   = 8'h7E;            // First byte of every frame
	localparam logic [7:0]  FRAME_TYPE   = 8'h2E;            // Session control request type
	localparam logic [7:0]  RESP_TYPE    = 8'hAE;            // Session response type
	localparam logic [7:0]  CSUM_TARGET  = 8'hFF;            // Body sum plus checksum
	localparam logic [63:0] BCAST_ADDR   = 64'h0000_0000_0000_FFFF; // Broadcast target

	// ==========================================================
	// Body byte positions, counted from the type byte
	localparam logic [15:0] IDX_TYPE     = 16'h0000;         // Type byte
	localparam logic [15:0] IDX_ADDR_LO  = 16'h0001;         // First address byte
	localparam logic [15:0] IDX_ADDR_HI  = 16'h0008;         // Last address byte
	localparam logic [15:0] IDX_OPT      = 16'h0009;         // Options byte
	localparam logic [15:0] IDX_TMO_HI   = 16'h000A;         // Timeout high byte
	localparam logic [15:0] IDX_TMO_LO   = 16'h000B;         // Timeout low byte
	localparam logic [15:0] IDX_PW       = 16'h000C;         // First password byte
	localparam logic [15:0] HDR_LEN      = 16'h000C;         // Body bytes before password
	localparam logic [15:0] PW_MAX_LEN   = 16'h0040;         // Longest password

	// ==========================================================
	// Option bit positions and timeout limit
	localparam int          OPT_LOGOUT   = 0;                // Client side end of session
	localparam int          OPT_SERVER   = 1;                // Server side termination
	localparam int          OPT_TTYPE    = 2;                // Timeout type select
	localparam logic [15:0] TMO_MAX      = 16'h4650;         // Largest accepted timeout
	localparam logic [15:0] TMO_YIELD    = 16'h0000;         // Timeout of a yielding session

	// ==========================================================
	// Response status codes
	localparam logic [7:0]  STAT_OK      = 8'h00;            // Login succeeded
	localparam logic [7:0]  STAT_FAIL    = 8'h01;            // Authentication failed
	localparam logic [7:0]  STAT_INVALID = 8'h0A;            // Invalid value in request

	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_WORD     = 16'h0000;         // Counters and fields
	localparam logic [7:0]  RST_BYTE     = 8'h00;            // Byte wide state

	// Receive state machine
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LEN_HI = 3'b001,
		ST_LEN_LO = 3'b010,
		ST_BODY   = 3'b011,
		ST_CSUM   = 3'b100,
		ST_EXEC   = 3'b101
	} sscf_state_t;

	// Decoded request fields
	typedef struct packed {
		logic [63:0] addr; // Target node
		logic [7:0]  opt; // Options byte
		logic [15:0] tmo; // Timeout field
	} sscf_cmd_t;

	// Login order handed to the authentication engine
	typedef struct packed {
		logic [63:0] addr; // Server to log into
		logic [15:0] tmo; // Session timeout
		logic        inter; // Inter-packet timeout
		logic        yield_s; // Yielding session
		logic [6:0]  pw_len; // Password length in bytes
	} sscf_login_t;

	// Response frame content
	typedef struct packed {
		logic [7:0]  ftype; // Response frame type
		logic [7:0]  status; // Outcome code
	} sscf_resp_t;

	// One incoming session slot
	typedef struct packed {
		logic        valid; // Slot in use
		logic        yield_s; // Session has zero timeout
		logic [7:0]  age; // Admissions since this one
		logic [63:0] addr; // Client node
	} sscf_slot_t;

endpackage

// ### verilog/sscf_pw_mem.sv
// Password buffer with a registered read port
`timescale 1ns/1ps

module sscf_pw_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data
);

	// ==========================================================
	// Parameter check
	if (WIDTH < 1 || DEPTH < 2) begin : g_bad_param
		$error("sscf_pw_mem: width or depth too small");
	end

	// Registered read state
	typedef struct packed {
		logic [WIDTH-1:0] rd_data; // Read data register
	} sscf_mem_state_t;

	logic [WIDTH-1:0] mem [DEPTH]; // Storage array
	sscf_mem_state_t  state_reg; // Current state
	sscf_mem_state_t  state_next; // Next state

	// Read data follows the address one cycle later
	always_comb begin
		state_next = state_reg;
		state_next.rd_data = mem[rd_addr];
	end

	// Read register with reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Storage is not reset; it is only read after it was written
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = state_reg.rd_data;

endmodule // sscf_pw_mem

// ### sim/sscf_props.sv
// Port-level concurrent checks on the session control frame decoder
`timescale 1ns/1ps

module sscf_props #(
	parameter int MAX_SESS = 4
) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire sscf_pkg::sscf_login_t login_cmd,
	input wire logic                  login_req,
	input wire logic                  logout_req,
	input wire logic                  resp_valid,
	input wire sscf_pkg::sscf_resp_t  resp,
	input wire logic                  in_req,
	input wire logic                  in_ack,
	input wire logic                  in_nak,
	input wire logic                  evict_valid,
	input wire logic                  term_valid,
	input wire logic [7:0]            sess_count,
	input wire logic                  frame_err
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========
	// Frame actions and incoming session requests
	a_login_one_cycle: assert property (login_req |=> !login_req)
		else $error("login held");
	a_login_not_bcast: assert property (login_req |-> login_cmd.addr != sscf_pkg::BCAST_ADDR)
		else $error("bcast login");
	a_login_tmo_max: assert property (login_req |-> login_cmd.tmo <= sscf_pkg::TMO_MAX)
		else $error("tmo over max");
	a_yield_marks_zero: assert property (login_req |-> login_cmd.yield_s == (login_cmd.tmo == 16'h0000))
		else $error("yield flag");
	a_logout_alone: assert property (logout_req |-> !login_req && !term_valid && !resp_valid)
		else $error("logout not alone");
	a_resp_type: assert property (resp_valid |-> resp.ftype == sscf_pkg::RESP_TYPE)
		else $error("resp type");
	a_err_quiet: assert property (frame_err |=> !login_req && !logout_req && !term_valid && !resp_valid)
		else $error("drop acted");
	a_req_answered: assert property (in_req |=> in_ack ^ in_nak)
		else $error("no answer");
	a_nak_only_full: assert property (in_nak |-> sess_count == MAX_SESS && !evict_valid)
		else $error("nak not full");
	a_evict_full: assert property (evict_valid |-> in_ack && sess_count == MAX_SESS)
		else $error("bad evict");

	// ==========
	// Scenario coverage
	c_login: cover property (login_req ##[1:60] resp_valid);
	c_evict: cover property (evict_valid);
	c_nak: cover property (in_nak);
endmodule // sscf_props

// ### sim/sscf_host_model.sv
// Host byte sender and authentication engine facing the decoder
`timescale 1ns/1ps

module sscf_host_model (
	input wire logic                  clk,
	output logic                      rx_valid,
	output logic [7:0]                rx_byte,
	input wire logic                  login_req,
	output logic [5:0]                pw_rd_addr,
	input wire logic [7:0]            pw_rd_data,
	output logic                      srp_done,
	output logic                      srp_ok,
	input wire logic                  ok_sel,
	input wire logic [3:0]            lat,
	output logic [7:0]                pw_first
);
	// One byte per cycle, changed just after the edge
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		#1 rx_valid = 1'b1;
		rx_byte = b;
	endtask

	// Whole frame; ln overrides the length, sa corrupts the checksum
	task automatic send_frame(input logic [7:0] ty, input logic [63:0] a, input logic [7:0] o,
		input logic [15:0] t, input int pw, input int ln, input logic [7:0] sa);
		logic [7:0] body[$];
		logic [15:0] len;
		logic [7:0] sum;
		body = {ty};
		for (int i = 0; i < 8; i++) body.push_back(a[63-8*i -: 8]);
		body.push_back(o);
		body.push_back(t[15:8]);
		body.push_back(t[7:0]);
		for (int i = 0; i < pw; i++) body.push_back(8'h41 + 8'(i));
		len = (ln != 0) ? 16'(ln) : 16'(body.size());
		sum = 8'h00;
		foreach (body[i]) sum += body[i];
		put(sscf_pkg::START_MARK);
		put(len[15:8]);
		put(len[7:0]);
		foreach (body[i]) put(body[i]);
		put(8'hFF - sum + sa);
		@(posedge clk);
		#1 rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask

	// Engine: read first password byte, answer after a chosen latency
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		srp_done = 1'b0;
		srp_ok = 1'b0;
		pw_rd_addr = 6'h00;
		pw_first = 8'h00;
		forever begin
			@(posedge clk);
			if (login_req === 1'b1) begin
				repeat (2) @(posedge clk);
				pw_first = pw_rd_data;
				repeat (lat) @(posedge clk);
				#1 srp_done = 1'b1;
				srp_ok = ok_sel;
				@(posedge clk);
				#1 srp_done = 1'b0;
				srp_ok = ~ok_sel;
			end
		end
	end
endmodule // sscf_host_model

// ### sim/sscf_frame_ctrl_tb_top.sv
// Self-checking bench for the session control frame decoder
`timescale 1ns/1ps

module sscf_frame_ctrl_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rx_valid, srp_done, srp_ok, ok_sel, in_req, in_yield;
	logic login_req, logout_req, resp_valid, in_ack, in_nak, evict_valid, term_valid, frame_err;
	logic [7:0] rx_byte, pw_rd_data, pw_first, sess_count;
	logic [5:0] pw_rd_addr;
	logic [3:0] lat;
	logic [63:0] in_addr, logout_addr, evict_addr;
	sscf_pkg::sscf_login_t login_cmd;
	sscf_pkg::sscf_resp_t resp;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int n_lg, n_lo, n_tm, n_rs, n_er;
	localparam logic [63:0] NODE = 64'h0042_5A00_1234_5678; // Arbitrary node address
	localparam logic [7:0] FT = sscf_pkg::FRAME_TYPE;

	always #2.5 clk = ~clk;

	sscf_frame_ctrl u_dut (.clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.login_cmd(login_cmd), .login_req(login_req), .pw_rd_addr(pw_rd_addr),
		.pw_rd_data(pw_rd_data), .logout_req(logout_req), .logout_addr(logout_addr),
		.srp_done(srp_done), .srp_ok(srp_ok), .resp_valid(resp_valid), .resp(resp),
		.in_req(in_req), .in_addr(in_addr), .in_yield(in_yield), .in_ack(in_ack),
		.in_nak(in_nak), .evict_valid(evict_valid), .evict_addr(evict_addr),
		.term_valid(term_valid), .sess_count(sess_count), .frame_err(frame_err));

	sscf_host_model u_host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.login_req(login_req), .pw_rd_addr(pw_rd_addr), .pw_rd_data(pw_rd_data),
		.srp_done(srp_done), .srp_ok(srp_ok), .ok_sel(ok_sel), .lat(lat), .pw_first(pw_first));

	// Pulse counters and hang limit
	always @(posedge clk) begin
		if (login_req === 1'b1) n_lg++;
		if (logout_req === 1'b1) n_lo++;
		if (term_valid === 1'b1) n_tm++;
		if (resp_valid === 1'b1) n_rs++;
		if (frame_err === 1'b1) n_er++;
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic chk(input string w, input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic frame(input logic [7:0] ty, input logic [63:0] a, input logic [7:0] o,
		input logic [15:0] t, input int pw, input int ln, input logic [7:0] sa);
		{n_lg, n_lo, n_tm, n_rs, n_er} = '0;
		u_host.send_frame(ty, a, o, t, pw, ln, sa);
		for (int i = 0; i < 60 && n_rs == 0; i++) @(posedge clk);
		#1;
	endtask

	task automatic t_login();
		ok_sel = 1'b1;
		lat = 4'h0;
		frame(FT, NODE, 8'h00, 16'h0BB8, 8, 0, 8'h00);
		chk("login", 64'(n_lg), 64'h1);
		chk("addr", login_cmd.addr, NODE);
		chk("tmo", 64'(login_cmd.tmo), 64'h0BB8);
		chk("inter", 64'(login_cmd.inter), 64'h0);
		chk("yield", 64'(login_cmd.yield_s), 64'h0);
		chk("pw_len", 64'(login_cmd.pw_len), 64'h8);
		chk("pw byte", 64'(pw_first), 64'h41);
		chk("type", 64'(resp.ftype), 64'hAE);
		chk("ok", 64'(resp.status), 64'(sscf_pkg::STAT_OK));
		ok_sel = 1'b0;
		lat = 4'h9;
		frame(FT, NODE, 8'h04, 16'h0000, 3, 0, 8'h00);
		chk("inter", 64'(login_cmd.inter), 64'h1);
		chk("yield", 64'(login_cmd.yield_s), 64'h1);
		chk("fail", 64'(resp.status), 64'(sscf_pkg::STAT_FAIL));
		for (int k = 0; k < 2; k++) begin
			frame(FT, k ? NODE : sscf_pkg::BCAST_ADDR, 8'h00, k ? 16'h4651 : 16'h0258, 4, 0, 8'h00);
			chk("no login", 64'(n_lg), 64'h0);
			chk("invalid", 64'(resp.status), 64'h0A);
		end
	endtask

	task automatic t_logout_bad();
		frame(FT, NODE, 8'h07, 16'h4651, 2, 0, 8'h00);
		chk("logout", 64'(n_lo), 64'h1);
		chk("logout addr", logout_addr, NODE);
		chk("others", 64'(n_lg + n_tm + n_rs), 64'h0);
		for (int k = 0; k < 3; k++) begin
			frame(k == 2 ? 8'h2D : FT, NODE, 8'h00, 16'h0010, 2, k == 1 ? 5 : 0, k == 0);
			chk("err", 64'(n_er), 64'(k < 2));
			chk("quiet", 64'(n_lg + n_lo + n_tm + n_rs), 64'h0);
		end
	endtask

	task automatic admit(input logic [63:0] a, input logic y, input logic ok, input logic [63:0] ev);
		@(posedge clk);
		#1 in_req = 1'b1;
		in_addr = a;
		in_yield = y;
		@(posedge clk);
		#1 in_req = 1'b0;
		chk("ack", 64'(in_ack), 64'(ok));
		chk("evict", 64'(evict_valid), 64'(ev != 64'h0));
		if (ev != 64'h0) chk("evict addr", evict_addr, ev);
	endtask

	task automatic t_sessions();
		admit(64'h11, 1'b1, 1'b1, 64'h0);
		admit(64'h12, 1'b0, 1'b1, 64'h0);
		admit(64'h13, 1'b1, 1'b1, 64'h0);
		admit(64'h14, 1'b0, 1'b1, 64'h0);
		admit(64'h15, 1'b0, 1'b1, 64'h11);
		admit(64'h16, 1'b0, 1'b1, 64'h13);
		admit(64'h17, 1'b1, 1'b0, 64'h0);
		frame(FT, 64'h12, 8'h02, 16'h0000, 0, 0, 8'h00);
		chk("term", 64'(n_tm), 64'h1);
		chk("count", 64'(sess_count), 64'h3);
		frame(FT, sscf_pkg::BCAST_ADDR, 8'h02, 16'h0000, 0, 0, 8'h00);
		chk("count", 64'(sess_count), 64'h0);
	endtask

	task automatic tally_and_finish();
		if (n_fail == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{in_req, in_yield, ok_sel, lat, in_addr} = '0;
		repeat (6) @(posedge clk);
		#1 rst_n = 1'b1;
		t_login();
		t_logout_bad();
		t_sessions();
		tally_and_finish();
	end
endmodule // sscf_frame_ctrl_tb_top

bind sscf_frame_ctrl sscf_props #(.MAX_SESS(MAX_SESS)) u_props (.clk(clk), .rst_n(rst_n),
	.login_cmd(login_cmd), .login_req(login_req), .logout_req(logout_req),
	.resp_valid(resp_valid), .resp(resp), .in_req(in_req), .in_ack(in_ack), .in_nak(in_nak),
	.evict_valid(evict_valid), .term_valid(term_valid), .sess_count(sess_count),
	.frame_err(frame_err));
